// ### dpram_port_host.sv
// host controller driving one port of the dual-port memory with mailbox and semaphores
// What this block does
// - right reads FFF to clear interrupt
// - on busy low, hold address and data
// - hold write strobe off for arbitration time
// - extend write strobe past busy release
// - request with zero, release with one
module dpram_port_host
  import dpram_host_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // user request side
  input wire logic req_valid,
  input wire dpram_host_pkg::host_req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  output logic rsp_sem_owned,
  // configuration: this port is right side, target is a slave device
  input wire logic is_right_port,
  input wire logic target_is_slave,
  // device port pins
  output dpram_host_pkg::port_ctl_t port_ctl,
  output logic [15:0] data_out,
  output logic data_oe,
  input wire logic [15:0] data_in,
  input wire logic busy_n_pin,
  input wire logic mbox_int_n_pin,
  // mailbox status toward user
  output logic mail_pending
);
  import dpram_host_pkg::*;

  typedef enum logic [4:0] {
    st_idle = 5'b00001,
    st_setup = 5'b00010,
    st_strobe = 5'b00100,
    st_hold = 5'b01000,
    st_done = 5'b10000
  } state_t;

  state_t state_r, state_nxt;
  host_req_t cur_r, cur_nxt; // latched request, held through busy
  logic [3:0] cnt_r, cnt_nxt; // cycle counter for setup/strobe/hold
  logic [15:0] rdata_r, rdata_nxt; // captured read data
  logic rsp_r, rsp_nxt; // one-cycle answer pulse
  logic busy_n, int_n; // synchronised pins

  pin_sync3 u_busy_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .pin_in(busy_n_pin),
    .reset_level(1'b1),
    .level_out(busy_n)
  );
  pin_sync3 u_int_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .pin_in(mbox_int_n_pin),
    .reset_level(1'b1),
    .level_out(int_n)
  );

  logic is_write, is_sem;
  assign is_write = cur_r.kind inside {op_ram_write, op_sem_write};
  assign is_sem = cur_r.kind inside {op_sem_read, op_sem_write};

  // sequencer next state
  always_comb begin
    state_nxt = state_r;
    cur_nxt = cur_r;
    cnt_nxt = cnt_r;
    rdata_nxt = rdata_r;
    rsp_nxt = 1'b0;
    unique case (state_r)
      st_idle: begin
        if (req_valid) begin
          cur_nxt = req;
          if (req.kind == op_sem_write) begin
            cur_nxt.wdata = {15'h0000, req.wdata[0]};
          end
          if (req.kind inside {op_sem_read, op_sem_write}) begin
            cur_nxt.addr = {9'h000, req.addr[2:0]};
          end
          // busy is only trusted once the synchroniser has caught up with it
          cnt_nxt = 4'(arb_cycles + sync_lag_cycles);
          state_nxt = st_setup;
        end
      end
      st_setup: begin
        // select and address out, strobe held off until busy has settled
        if (cnt_r != cnt_zero) begin
          cnt_nxt = cnt_r - 4'h1;
        end else if (!busy_n) begin
          cnt_nxt = cnt_zero; // hold address, wait
        end else begin
          cnt_nxt = 4'(access_cycles);
          state_nxt = st_strobe;
        end
      end
      st_strobe: begin
        if (!busy_n) begin
          // lost arbitration mid-access: operation invalid, stay put
          cnt_nxt = 4'(access_cycles);
        end else if (cnt_r != cnt_zero) begin
          cnt_nxt = cnt_r - 4'h1;
        end else begin
          // writes leave the last read word in place for the user
          if (!is_write) begin
            rdata_nxt = data_in; // semaphore reads replicate the flag
          end
          cnt_nxt = 4'(wr_hold_cycles);
          state_nxt = is_write ? st_hold : st_done;
        end
      end
      st_hold: begin
        // write strobe extended past busy release; slaves block on busy low
        if (!busy_n && target_is_slave) begin
          cnt_nxt = 4'(wr_hold_cycles);
        end else if (cnt_r != cnt_zero) begin
          cnt_nxt = cnt_r - 4'h1;
        end else begin
          state_nxt = st_done;
        end
      end
      st_done: begin
        rsp_nxt = 1'b1;
        state_nxt = st_idle;
      end
      default: state_nxt = st_idle;
    endcase
  end

  // sequencer registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_r <= st_idle;
      cur_r <= '0;
      cnt_r <= cnt_zero;
      rdata_r <= 16'h0000;
      rsp_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cur_r <= cur_nxt;
      cnt_r <= cnt_nxt;
      rdata_r <= rdata_nxt;
      rsp_r <= rsp_nxt;
    end
  end

  logic active, strobe;
  assign active = (state_r != st_idle) && (state_r != st_done);
  assign strobe = (state_r == st_strobe) || (state_r == st_hold);

  // pin drive; the port idles in standby with all selects high
  always_comb begin
    port_ctl.chip_sel_n = !(active && !is_sem);
    port_ctl.sem_space_select_n = !(active && is_sem);
    port_ctl.rd_wr_n = !(strobe && is_write);
    port_ctl.out_en_n = !(strobe && !is_write);
    port_ctl.addr = cur_r.addr; // stable for whole access
  end

  assign data_out = cur_r.wdata; // mailbox data is ordinary data
  assign data_oe = active && is_write;

  assign req_ready = (state_r == st_idle);
  assign rsp_valid = rsp_r;
  assign rsp_data = rdata_r;
  assign rsp_sem_owned = (rdata_r[0] == sem_request);

  // mailbox: a message waits from the interrupt's fall until own box is read
  logic mail_r, mail_nxt; // pending message flag
  logic int_prev_r, int_prev_nxt; // last synchronised interrupt level
  logic [11:0] own_box; // this port's mailbox word
  logic box_read_done; // a plain read of own box has just finished

  // left port owns ffe, right port owns fff
  assign own_box = is_right_port ? mbox_right_addr : mbox_left_addr;
  assign box_read_done = (state_r == st_done) && !is_write && !is_sem
    && (cur_r.addr == own_box);

  // next values: clear on own read, set on a new falling edge; set wins
  // limitation: a second message while one waits raises no new edge
  always_comb begin
    int_prev_nxt = int_n;
    mail_nxt = mail_r;
    if (box_read_done) begin
      mail_nxt = 1'b0;
    end
    if (int_prev_r && !int_n) begin
      mail_nxt = 1'b1;
    end
  end

  // mailbox registers; edge detector resets to the pin's idle level
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mail_r <= 1'b0;
      int_prev_r <= 1'b1;
    end else begin
      mail_r <= mail_nxt;
      int_prev_r <= int_prev_nxt;
    end
  end

  // flag from a flop, so the user never sees a glitch of the pin
  assign mail_pending = mail_r;
endmodule

// ### dpram_host_pkg.sv
// package: pin groups, mailbox and semaphore constants, timing counts for the host controller
package dpram_host_pkg;
  localparam int unsigned addr_w = 12;
  localparam int unsigned data_w = 16;
  localparam logic [11:0] mbox_left_addr = 12'hffe; // left mailbox word
  localparam logic [11:0] mbox_right_addr = 12'hfff; // right mailbox word
  localparam int unsigned sem_count = 8;
  localparam int unsigned clk_period_ns = 50;
  // time the device's arbiter needs to settle busy, in ns
  localparam int unsigned arb_time_ns = 5;
  localparam int unsigned arb_cycles = (arb_time_ns + clk_period_ns - 1) / clk_period_ns;
  // edges from a pin change to the synchronised level: three flops plus agreement
  localparam int unsigned sync_lag_cycles = 4;
  // write hold beyond busy release, in ns
  localparam int unsigned wr_hold_ns = 50;
  localparam int unsigned wr_hold_cycles = (wr_hold_ns + clk_period_ns - 1) / clk_period_ns;
  // access strobe length, in ns
  localparam int unsigned access_ns = 100;
  localparam int unsigned access_cycles = (access_ns + clk_period_ns - 1) / clk_period_ns;
  localparam logic [3:0] cnt_zero = 4'h0;
  localparam logic sem_request = 1'b0; // write zero to take a token
  localparam logic sem_release = 1'b1; // write one to give it back

  typedef enum logic [1:0] {
    op_ram_read = 2'h0,
    op_ram_write = 2'h1,
    op_sem_read = 2'h2,
    op_sem_write = 2'h3
  } op_kind_t;

  // one user request
  typedef struct packed {
    op_kind_t kind;
    logic [11:0] addr;
    logic [15:0] wdata;
  } host_req_t;

  // pins driven toward one device port
  typedef struct packed {
    logic chip_sel_n;
    logic sem_space_select_n;
    logic rd_wr_n;
    logic out_en_n;
    logic [11:0] addr;
  } port_ctl_t;
endpackage

// ### pin_sync3.sv
// three-stage synchroniser; output changes once stages two and three agree
module pin_sync3 (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // pin in, clean level out
  input wire logic pin_in,
  input wire logic reset_level,
  output logic level_out
);
  logic s1_r, s2_r, s3_r, lvl_r;
  logic s1_nxt, s2_nxt, s3_nxt, lvl_nxt;

  // next values: shift, accept only when last two stages agree
  always_comb begin
    s1_nxt = pin_in;
    s2_nxt = s1_r;
    s3_nxt = s2_r;
    lvl_nxt = (s2_r == s3_r) ? s3_r : lvl_r;
  end

  // registers; reset is synchronous so reset_level may be a signal
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s1_r <= reset_level;
      s2_r <= reset_level;
      s3_r <= reset_level;
      lvl_r <= reset_level;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  assign level_out = lvl_r;
endmodule

// ### dp_checker.sv
// checker: timing relations on the host controller's ports
module dp_checker
  import dpram_host_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // user side
  input wire logic req_ready,
  input wire logic rsp_valid,
  // device pins
  input wire dpram_host_pkg::port_ctl_t port_ctl,
  input wire logic [15:0] data_out,
  input wire logic data_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // either space selected
  wire sel = !(port_ctl.chip_sel_n && port_ctl.sem_space_select_n);
  a_idle_standby: assert property (req_ready |-> !sel)
    else $error("port selected while idle");
  a_drive_excl: assert property (data_oe |-> port_ctl.out_en_n)
    else $error("bus driven while device drives");
  a_oe_read: assert property (!port_ctl.out_en_n |-> port_ctl.rd_wr_n)
    else $error("output enable during write");
  a_one_space: assert property (!(!port_ctl.chip_sel_n && !port_ctl.sem_space_select_n))
    else $error("both spaces selected");
  a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid && req_ready)
    else $error("response not a single pulse");
  a_addr_held: assert property (sel && $past(sel) |-> $stable(port_ctl.addr))
    else $error("address moved during access");
  a_wdata_held: assert property (!port_ctl.rd_wr_n && $past(!port_ctl.rd_wr_n) |-> $stable(data_out))
    else $error("write data moved during strobe");
  // select must lead the write strobe by the arbitration and sync wait
  a_strobe_setup: assert property ($fell(port_ctl.rd_wr_n) |-> $past(sel, 5))
    else $error("write strobe without setup");
endmodule

// ### dp_device_model.sv
// behavioural device port: memory, mailbox flag, semaphores
module dp_device_model
  import dpram_host_pkg::*;
(
  input wire logic mclk,
  // host pins
  input wire dpram_host_pkg::port_ctl_t port_ctl,
  input wire logic [15:0] data_out,
  input wire logic data_oe,
  input wire logic busy_n,
  output logic [15:0] data_in,
  output logic int_n,
  // far port stimulus
  input wire logic o_mail,
  input wire logic o_sem_we,
  input wire logic [2:0] o_idx,
  input wire logic o_val
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [0:4095];
  logic [15:0] junk_r; // released bus: changes each cycle
  logic [7:0] rq_h, rq_o, own_h, own_o; // request latches, owners
  wire sel_ram = !port_ctl.chip_sel_n;
  wire sel_sem = !port_ctl.sem_space_select_n;
  wire rd = port_ctl.rd_wr_n && !port_ctl.out_en_n;
  initial begin
    rq_h = '0; rq_o = '0; own_h = '0; own_o = '0; int_n = 1'b1; junk_r = 16'h0;
  end
  // release first, then grant; a tie goes to this port
  task upd;
    own_h &= rq_h;
    own_o &= rq_o;
    own_h |= rq_h & ~own_o;
    own_o |= rq_o & ~own_h;
  endtask
  always @(posedge mclk) junk_r <= junk_r + 16'h3b1d;
  // writes suppressed while busy is low
  always @(port_ctl or data_out or busy_n) begin
    if (!port_ctl.rd_wr_n && busy_n && data_oe) begin
      if (sel_ram) mem[port_ctl.addr] = data_out;
      if (sel_sem) begin
        rq_h[port_ctl.addr[2:0]] = !data_out[0];
        upd();
      end
    end
    if (rd && sel_ram && port_ctl.addr == mbox_left_addr) int_n = 1'b1;
  end
  always @(posedge o_mail) int_n = 1'b0;
  always @(posedge o_sem_we) begin
    rq_o[o_idx] = !o_val;
    upd();
  end
  always @* begin
    if (rd && sel_ram) data_in = mem[port_ctl.addr];
    else if (rd && sel_sem) data_in = {16{!own_h[port_ctl.addr[2:0]]}};
    else data_in = junk_r;
  end
endmodule

// ### testbench.sv
// top bench: host controller against device model
module testbench;
  import dpram_host_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, sys_rst, req_valid, target_is_slave, busy_n, o_mail, o_sem_we, o_val;
  logic req_ready, rsp_valid, rsp_sem_owned, data_oe, int_n, mail_pending;
  logic [2:0] o_idx;
  logic [15:0] rsp_data, data_out, data_in, got;
  logic [15:0] shadow [0:15];
  logic [11:0] a [0:15];
  host_req_t req;
  port_ctl_t port_ctl;
  int fails, checked;
  dpram_port_host DUT (.mclk, .sys_rst, .req_valid, .req, .req_ready, .rsp_valid, .rsp_data,
    .rsp_sem_owned, .is_right_port(1'b0), .target_is_slave, .port_ctl, .data_out, .data_oe,
    .data_in, .busy_n_pin(busy_n), .mbox_int_n_pin(int_n), .mail_pending);
  dp_device_model dev (.mclk, .port_ctl, .data_out, .data_oe, .busy_n, .data_in, .int_n,
    .o_mail, .o_sem_we, .o_idx, .o_val);
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  function automatic logic [15:0] sem_word(input logic b);
    return {16{b}};
  endfunction
  task check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one request, bounded wait for the response pulse
  task op(input op_kind_t k, input logic [11:0] ad, input logic [15:0] wd);
    int n;
    @(negedge mclk);
    req = '{k, ad, wd};
    req_valid = 1'b1;
    @(negedge mclk);
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 400) begin
      @(negedge mclk);
      n++;
    end
    if (n == 400) fails++;
    got = rsp_data;
  endtask
  // far port semaphore write
  task osem(input logic [2:0] ix, input logic v);
    @(negedge mclk);
    o_idx = ix;
    o_val = v;
    o_sem_we = 1'b1;
    @(negedge mclk);
    o_sem_we = 1'b0;
  endtask
  initial begin
    #500000;
    fails++;
    close_out();
  end
  initial begin
    fails = 0; checked = 0; sys_rst = 1'b1; req_valid = 1'b0; req = '0; target_is_slave = 1'b0;
    busy_n = 1'b1; o_mail = 1'b0; o_sem_we = 1'b0; o_idx = 3'h0; o_val = 1'b1;
    void'($urandom(32'h4b33));
    repeat (12) @(negedge mclk);
    sys_rst = 1'b0;
    // random words, the last two land on the mailbox words
    for (int i = 0; i < 16; i++) begin
      a[i] = (i > 13) ? {8'hff, 4'(i)} : {8'($urandom % 255), 4'(i)};
      shadow[i] = 16'($urandom);
      op(op_ram_write, a[i], shadow[i]);
    end
    for (int i = 0; i < 16; i++) begin
      op(op_ram_read, a[i], 16'h0);
      check(got, shadow[i]);
    end
    @(negedge mclk) o_mail = 1'b1;
    @(negedge mclk) o_mail = 1'b0;
    repeat (6) @(negedge mclk);
    check(16'(mail_pending), 16'h1);
    op(op_ram_read, mbox_right_addr, 16'h0);
    check(got, shadow[15]);
    check(16'(mail_pending), 16'h1);
    op(op_ram_read, mbox_left_addr, 16'h0);
    repeat (6) @(negedge mclk);
    check(16'(mail_pending), 16'h0);
    for (int i = 0; i < 8; i++) begin
      op(op_sem_write, {9'($urandom), 3'(i)}, {15'($urandom), sem_request});
      op(op_sem_read, {9'($urandom), 3'(i)}, 16'h0);
      check(got, sem_word(1'b0));
      check(16'(rsp_sem_owned), 16'h1);
    end
    osem(3'h0, 1'b0);
    op(op_sem_read, 12'h0, 16'h0);
    check(got, sem_word(1'b0));
    op(op_sem_write, 12'h0, 16'hfff1);
    op(op_sem_read, 12'h0, 16'h0);
    check(got, sem_word(1'b1));
    op(op_sem_write, 12'h0, 16'hfffe);
    op(op_sem_read, 12'h0, 16'h0);
    check(got, sem_word(1'b1));
    osem(3'h0, 1'b1);
    op(op_sem_read, 12'h0, 16'h0);
    check(got, sem_word(1'b0));
    // slave target: write held off while busy is low
    target_is_slave = 1'b1;
    fork
      op(op_ram_write, 12'h123, 16'hbeef);
      begin
        busy_n = 1'b0;
        for (int k = 0; k < 20; k++) begin
          @(negedge mclk);
          check(16'(rsp_valid), 16'h0);
        end
        busy_n = 1'b1;
      end
    join
    op(op_ram_read, 12'h123, 16'h0);
    check(got, 16'hbeef);
    close_out();
  end
endmodule
bind dpram_port_host dp_checker chk (.mclk, .sys_rst, .req_ready, .rsp_valid, .port_ctl,
  .data_out, .data_oe);
